// [include/esd_pkg.sv]
// shared constants and carrier types of the exception dispatch unit
package esd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TBASE = 8'h04;
  localparam logic [7:0] OFS_TSAVE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_LASTVEC = 8'h14;
  localparam logic [31:0] TBASE_RST = 32'h0000_0000;
  localparam logic [31:0] TSAVE_RST = 32'h0000_1000;

  // ----------------------------------------------------------------
  // vectors, event bits, sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_BP = 8'h03;
  localparam logic [7:0] VEC_OF = 8'h04;
  localparam logic [7:0] VEC_BR = 8'h05;
  localparam logic [7:0] VEC_MF = 8'h10;
  localparam logic [7:0] VEC_XF = 8'h13;
  localparam int EV_N = 8;
  localparam int EV_BP = 0;
  localparam int EV_OF = 1;
  localparam int EV_BR = 2;
  localparam int EV_MF = 3;
  localparam int EV_XF = 4;
  localparam int EV_SOFT = 5;
  localparam int EV_TASK = 6;
  localparam int EV_RET = 7;
  localparam logic [3:0] STEP_REAL = 4'h2;
  localparam logic [3:0] STEP_LEG = 4'h4;
  localparam logic [3:0] STEP_LONG = 4'h8;
  localparam int SH_REAL = 2;
  localparam int SH_LEG = 3;
  localparam int SH_LONG = 4;
  localparam int SLOT_SH = 3;
  localparam logic [15:0] NULL_SEL = 16'h0000;

  // stack items, pushed lowest index first and popped highest first
  localparam int P_SS = 0;
  localparam int P_SP = 1;
  localparam int P_FL = 2;
  localparam int P_CS = 3;
  localparam int P_IP = 4;
  localparam int P_ERR = 5;
  localparam logic [5:0] PM_CTX = 6'h1f;
  localparam logic [5:0] PM_FRAME = 6'h1c;
  localparam logic [5:0] PM_STK = 6'h03;
  localparam logic [5:0] PM_ERR = 6'h20;

  typedef enum logic [1:0] {
    ESD_REAL = 2'h0,
    ESD_LEGACY = 2'h1,
    ESD_LONG = 2'h2
  } esd_mode_t;

  typedef enum logic [3:0] {
    K_EXT = 4'h0,
    K_SOFT = 4'h1,
    K_OVF = 4'h2,
    K_BRK = 4'h3,
    K_BOUND = 4'h4,
    K_FPU = 4'h5,
    K_SIMD = 4'h6,
    K_RET = 4'h7
  } esd_kind_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_SAVE = 6'h02,
    S_FETCH = 6'h04,
    S_PUSH = 6'h08,
    S_POP = 6'h10,
    S_REDIR = 6'h20
  } esd_fsm_t;

  typedef struct packed {
    logic [31:0] flags;
    logic [63:0] ip;
    logic [15:0] cs;
    logic [15:0] ss;
    logic [63:0] sp;
  } esd_ctx_t;

  typedef struct packed {
    esd_kind_t kind;
    logic [7:0] vector;
    logic ovf;
    logic signed [31:0] operand;
    logic signed [31:0] lower;
    logic signed [31:0] upper;
    logic err_valid;
    logic [31:0] err_code;
    esd_ctx_t ctx;
    logic [1:0] current_privilege;
    logic [1:0] dpl;
    logic task_gate;
    logic system_mgmt_interrupt;
  } esd_req_t;

  typedef struct packed {
    logic valid;
    logic code64;
    esd_ctx_t ctx;
  } esd_redir_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [63:0] addr;
    logic [63:0] wdata;
    logic [3:0] bytes;
  } esd_mem_t;

  typedef struct packed {
    esd_fsm_t fsm;
    esd_mode_t mode;
    logic [31:0] tbase;
    logic [31:0] tsave;
    logic [EV_N-1:0] status;
    logic [EV_N-1:0] mask;
    logic [7:0] vec;
    esd_ctx_t ctx;
    logic [63:0] wsp;
    logic [63:0] nip;
    logic [15:0] ncs;
    logic [31:0] err;
    logic errv;
    logic chg;
    logic system_mgmt_interrupt;
    logic is_ret;
    logic from_save;
    logic in_task;
    logic spl;
    logic [5:0] pend;
    esd_mem_t mem;
    esd_redir_t redir;
    logic done;
    logic busy;
    logic irq;
    logic [31:0] rdata;
  } esd_state_t;

endpackage

// [rtl/esd_dispatch.sv]
// interrupt and exception dispatch: vector decode, stack frames, task switch
//
// Implementation choices: the plain strobed port and the address map.

// Behaviour
// - real mode: vector indexes handler table, then far call to handler
// - real mode: push flags, code selector, instruction pointer, error code if any
// - real mode: handler return instruction pops the frame and resumes
// - soft interrupt dispatches to whatever vector its operand names
// - overflow trap raises vector 4 only when overflow_flag set
// - arithmetic never raises overflow_exception; only trap or soft vector 4; external vector 4 also sets the overflow event here
// - breakpoint instruction always raises vector 3
// - range check outside memory limits raises bound_range_exception, vector 5
// - no implicit bound checks; only range check or soft vector 5; external vector 5 also sets the bound event here
// - six floating-point conditions from scalar stack and packed SIMD operations
// - scalar errors raise fpu_error_exception, packed ones simd_fp_exception
// - 64-bit mode: every interrupt push is an 8-byte zero-extended store
// - 64-bit mode always pushes stack selector and pointer; legacy only on privilege change
// - 64-bit mode: privilege change loads null new stack selector
// - 64-bit mode handlers run as 64-bit code, except system management
// - task gate: save full interrupted state, then switch to handler task
// - handler task return restores saved state and resumes there
// - fpu_error_exception uses vector 16
module esd_dispatch #(
  parameter int REG_AW = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [REG_AW-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic req_valid_in,
  input wire esd_pkg::esd_req_t req_in,
  input wire logic [5:0] fp_cond_in,
  output logic busy_out,
  output logic done_out,
  output esd_pkg::esd_redir_t redir_out,
  output esd_pkg::esd_mem_t mem_out,
  input wire logic mem_ack_in,
  input wire logic [63:0] mem_rdata_in,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] step(input esd_pkg::esd_mode_t m);
    case (m)
      esd_pkg::ESD_REAL: step = esd_pkg::STEP_REAL;
      esd_pkg::ESD_LONG: step = esd_pkg::STEP_LONG;
      default: step = esd_pkg::STEP_LEG;
    endcase
  endfunction

  function automatic logic [2:0] lsb6(input logic [5:0] v);
    lsb6 = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (v[i]) begin
        lsb6 = 3'(i);
      end
    end
  endfunction

  function automatic logic [2:0] msb6(input logic [5:0] v);
    msb6 = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (v[i]) begin
        msb6 = 3'(i);
      end
    end
  endfunction

  function automatic logic [63:0] item(input esd_pkg::esd_ctx_t c, input logic [31:0] e, input logic [2:0] k);
    case (k)
      3'(esd_pkg::P_SS): item = 64'(c.ss);
      3'(esd_pkg::P_SP): item = c.sp;
      3'(esd_pkg::P_FL): item = 64'(c.flags);
      3'(esd_pkg::P_CS): item = 64'(c.cs);
      3'(esd_pkg::P_IP): item = c.ip;
      default: item = 64'(e);
    endcase
  endfunction

  initial begin
    if (REG_AW < 5 || REG_AW > 8) begin
      $error("REG_AW must be 5 to 8");
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int EV_N_W = esd_pkg::EV_N;
  esd_pkg::esd_state_t st;
  esd_pkg::esd_state_t next_st;
  logic acc;
  logic raise;
  logic [7:0] dvec;
  logic [EV_N_W-1:0] ev;
  logic [EV_N_W-1:0] clr;
  logic [2:0] pick;
  logic [3:0] stp;
  logic out_rng;

  assign acc = req_valid_in && (st.fsm == esd_pkg::S_IDLE);
  assign stp = step(st.mode);
  assign out_rng = (req_in.operand < req_in.lower) || (req_in.operand > req_in.upper);

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.redir.valid = 1'b0;
    next_st.rdata = 32'h0;
    ev = '0;
    clr = '0;
    raise = 1'b0;
    dvec = req_in.vector;
    pick = 3'h0;

    // --------------------------------------------------------------
    // register port
    // --------------------------------------------------------------
    if (reg_wr_in) begin
      case (8'(reg_addr_in))
        esd_pkg::OFS_CTRL: next_st.mode = esd_pkg::esd_mode_t'(reg_wdata_in[1:0]);
        esd_pkg::OFS_TBASE: next_st.tbase = reg_wdata_in;
        esd_pkg::OFS_TSAVE: next_st.tsave = reg_wdata_in;
        esd_pkg::OFS_STATUS: clr = reg_wdata_in[EV_N_W-1:0];
        esd_pkg::OFS_MASK: next_st.mask = reg_wdata_in[EV_N_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (8'(reg_addr_in))
        esd_pkg::OFS_CTRL: next_st.rdata = 32'(st.mode);
        esd_pkg::OFS_TBASE: next_st.rdata = st.tbase;
        esd_pkg::OFS_TSAVE: next_st.rdata = st.tsave;
        esd_pkg::OFS_STATUS: next_st.rdata = 32'(st.status);
        esd_pkg::OFS_MASK: next_st.rdata = 32'(st.mask);
        esd_pkg::OFS_LASTVEC: next_st.rdata = {st.busy, st.in_task, 22'h0, st.vec};
        default: next_st.rdata = 32'h0;
      endcase
    end

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    case (st.fsm)
      esd_pkg::S_IDLE: begin
        if (acc) begin
          case (req_in.kind)
            esd_pkg::K_EXT, esd_pkg::K_SOFT: raise = 1'b1;
            esd_pkg::K_OVF: begin
              raise = req_in.ovf;
              dvec = esd_pkg::VEC_OF;
            end
            esd_pkg::K_BRK: begin
              raise = 1'b1;
              dvec = esd_pkg::VEC_BP;
            end
            esd_pkg::K_BOUND: begin
              raise = out_rng;
              dvec = esd_pkg::VEC_BR;
            end
            esd_pkg::K_FPU: begin
              raise = |fp_cond_in;
              dvec = esd_pkg::VEC_MF;
            end
            esd_pkg::K_SIMD: begin
              raise = |fp_cond_in;
              dvec = esd_pkg::VEC_XF;
            end
            default: raise = 1'b0;
          endcase
          next_st.ctx = req_in.ctx;
          next_st.wsp = req_in.ctx.sp;
          next_st.err = req_in.err_code;
          next_st.errv = req_in.err_valid;
          next_st.chg = req_in.dpl != req_in.current_privilege;
          next_st.system_mgmt_interrupt = req_in.system_mgmt_interrupt;
          next_st.spl = 1'b0;
          if (req_in.kind == esd_pkg::K_RET) begin
            next_st.is_ret = 1'b1;
            next_st.fsm = esd_pkg::S_POP;
            if (st.in_task) begin
              next_st.from_save = 1'b1;
              next_st.in_task = 1'b0;
              next_st.pend = esd_pkg::PM_CTX;
            end else begin
              next_st.from_save = 1'b0;
              next_st.pend = esd_pkg::PM_FRAME;
              if (st.mode == esd_pkg::ESD_LONG || (st.mode != esd_pkg::ESD_REAL && req_in.dpl != req_in.current_privilege)) begin
                next_st.pend = esd_pkg::PM_CTX;
              end
            end
          end else if (raise) begin
            next_st.is_ret = 1'b0;
            next_st.from_save = 1'b0;
            next_st.vec = dvec;
            // overflow event from any request dispatched to vector 4, external ones included
            ev[esd_pkg::EV_OF] = dvec == esd_pkg::VEC_OF;
            ev[esd_pkg::EV_BP] = dvec == esd_pkg::VEC_BP;
            // bound event from any request dispatched to vector 5, external ones included
            ev[esd_pkg::EV_BR] = dvec == esd_pkg::VEC_BR;
            ev[esd_pkg::EV_MF] = dvec == esd_pkg::VEC_MF;
            ev[esd_pkg::EV_XF] = dvec == esd_pkg::VEC_XF;
            ev[esd_pkg::EV_SOFT] = req_in.kind == esd_pkg::K_SOFT;
            if (req_in.task_gate && st.mode != esd_pkg::ESD_REAL) begin
              next_st.fsm = esd_pkg::S_SAVE;
              next_st.pend = esd_pkg::PM_CTX;
              next_st.in_task = 1'b1;
            end else begin
              next_st.fsm = esd_pkg::S_FETCH;
              next_st.pend = esd_pkg::PM_FRAME | (req_in.err_valid ? esd_pkg::PM_ERR : 6'h00);
              if (st.mode == esd_pkg::ESD_LONG || (st.mode != esd_pkg::ESD_REAL && req_in.dpl != req_in.current_privilege)) begin
                next_st.pend = next_st.pend | esd_pkg::PM_STK;
              end
            end
          end else begin
            // trap not taken: fall through
            next_st.done = 1'b1;
          end
        end
      end
      esd_pkg::S_SAVE: begin
        if (mem_ack_in) begin
          next_st.pend[lsb6(st.pend)] = 1'b0;
          if (next_st.pend == 6'h00) begin
            ev[esd_pkg::EV_TASK] = 1'b1;
            next_st.pend = st.errv ? esd_pkg::PM_ERR : 6'h00;
            next_st.fsm = esd_pkg::S_FETCH;
          end
        end
      end
      esd_pkg::S_FETCH: begin
        if (mem_ack_in) begin
          case (st.mode)
            esd_pkg::ESD_REAL: begin
              next_st.nip = 64'(mem_rdata_in[15:0]);
              next_st.ncs = mem_rdata_in[31:16];
            end
            esd_pkg::ESD_LONG: begin
              next_st.nip = 64'(mem_rdata_in[47:0]);
              next_st.ncs = mem_rdata_in[63:48];
            end
            default: begin
              next_st.nip = 64'(mem_rdata_in[31:0]);
              next_st.ncs = mem_rdata_in[47:32];
            end
          endcase
          next_st.fsm = (st.pend == 6'h00) ? esd_pkg::S_REDIR : esd_pkg::S_PUSH;
        end
      end
      esd_pkg::S_PUSH: begin
        if (mem_ack_in) begin
          next_st.pend[lsb6(st.pend)] = 1'b0;
          next_st.wsp = st.wsp - 64'(stp);
          if (next_st.pend == 6'h00) begin
            next_st.fsm = esd_pkg::S_REDIR;
          end
        end
      end
      esd_pkg::S_POP: begin
        if (mem_ack_in) begin
          pick = msb6(st.pend);
          next_st.pend[pick] = 1'b0;
          if (!st.from_save) begin
            next_st.wsp = st.wsp + 64'(stp);
          end
          case (pick)
            3'(esd_pkg::P_SS): next_st.ctx.ss = mem_rdata_in[15:0];
            3'(esd_pkg::P_SP): next_st.ctx.sp = mem_rdata_in;
            3'(esd_pkg::P_FL): next_st.ctx.flags = mem_rdata_in[31:0];
            3'(esd_pkg::P_CS): next_st.ctx.cs = mem_rdata_in[15:0];
            default: next_st.ctx.ip = mem_rdata_in;
          endcase
          if (pick == 3'(esd_pkg::P_SP)) begin
            next_st.spl = 1'b1;
          end
          if (next_st.pend == 6'h00) begin
            ev[esd_pkg::EV_RET] = 1'b1;
            next_st.fsm = esd_pkg::S_REDIR;
          end
        end
      end
      esd_pkg::S_REDIR: begin
        next_st.redir.valid = 1'b1;
        next_st.done = 1'b1;
        next_st.fsm = esd_pkg::S_IDLE;
        if (st.is_ret) begin
          next_st.redir.ctx = st.ctx;
          next_st.redir.ctx.sp = st.spl ? st.ctx.sp : st.wsp;
          next_st.redir.code64 = st.mode == esd_pkg::ESD_LONG;
        end else begin
          next_st.redir.ctx = st.ctx;
          next_st.redir.ctx.ip = st.nip;
          next_st.redir.ctx.cs = st.ncs;
          next_st.redir.ctx.sp = st.wsp;
          // null stack selector on privilege change
          if (st.mode == esd_pkg::ESD_LONG && st.chg) begin
            next_st.redir.ctx.ss = esd_pkg::NULL_SEL;
          end
          // system management handler keeps its own mode
          next_st.redir.code64 = st.mode == esd_pkg::ESD_LONG && !st.system_mgmt_interrupt;
        end
      end
      default: next_st.fsm = esd_pkg::S_IDLE;
    endcase

    // --------------------------------------------------------------
    // memory request for the next cycle, taken from the next state
    // --------------------------------------------------------------
    next_st.mem = '0;
    pick = (next_st.fsm == esd_pkg::S_POP) ? msb6(next_st.pend) : lsb6(next_st.pend);
    next_st.mem.bytes = step(next_st.mode);
    case (next_st.fsm)
      esd_pkg::S_SAVE, esd_pkg::S_POP: begin
        next_st.mem.req = 1'b1;
        next_st.mem.we = next_st.fsm == esd_pkg::S_SAVE;
        if (next_st.fsm == esd_pkg::S_SAVE || next_st.from_save) begin
          next_st.mem.bytes = esd_pkg::STEP_LONG;
          next_st.mem.addr = 64'(next_st.tsave) + (64'(pick) << esd_pkg::SLOT_SH);
        end else begin
          next_st.mem.addr = next_st.wsp;
        end
        next_st.mem.wdata = item(next_st.ctx, next_st.err, pick);
      end
      esd_pkg::S_FETCH: begin
        next_st.mem.req = 1'b1;
        next_st.mem.bytes = esd_pkg::STEP_LONG;
        case (next_st.mode)
          esd_pkg::ESD_REAL: next_st.mem.addr = 64'(next_st.tbase) + (64'(next_st.vec) << esd_pkg::SH_REAL);
          esd_pkg::ESD_LONG: next_st.mem.addr = 64'(next_st.tbase) + (64'(next_st.vec) << esd_pkg::SH_LONG);
          default: next_st.mem.addr = 64'(next_st.tbase) + (64'(next_st.vec) << esd_pkg::SH_LEG);
        endcase
      end
      esd_pkg::S_PUSH: begin
        next_st.mem.req = 1'b1;
        next_st.mem.we = 1'b1;
        next_st.mem.addr = next_st.wsp - 64'(next_st.mem.bytes);
        next_st.mem.wdata = item(next_st.ctx, next_st.err, pick);
        // zero-extended store of the push width
        case (next_st.mode)
          esd_pkg::ESD_REAL: next_st.mem.wdata = 64'(next_st.mem.wdata[15:0]);
          esd_pkg::ESD_LONG: next_st.mem.wdata = next_st.mem.wdata;
          default: next_st.mem.wdata = 64'(next_st.mem.wdata[31:0]);
        endcase
      end
      default: ;
    endcase

    // set wins over a write-one clear in the same cycle
    next_st.status = (st.status & ~clr) | ev;
    next_st.irq = |(next_st.status & next_st.mask);
    next_st.busy = next_st.fsm != esd_pkg::S_IDLE;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
      st.fsm <= esd_pkg::S_IDLE;
      st.mode <= esd_pkg::ESD_REAL;
      st.tbase <= esd_pkg::TBASE_RST;
      st.tsave <= esd_pkg::TSAVE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out = st.rdata;
  assign busy_out = st.busy;
  assign done_out = st.done;
  assign redir_out = st.redir;
  assign mem_out = st.mem;
  assign irq_out = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_brk_vector: assert property (acc && req_in.kind == esd_pkg::K_BRK |=> st.vec == esd_pkg::VEC_BP && busy_out)
    else $error("breakpoint not dispatched to vector 3");
  a_ovf_skip: assert property (acc && req_in.kind == esd_pkg::K_OVF && !req_in.ovf |=> done_out && !busy_out)
    else $error("overflow trap taken with flag clear");
  a_ovf_take: assert property (acc && req_in.kind == esd_pkg::K_OVF && req_in.ovf |=> st.vec == esd_pkg::VEC_OF)
    else $error("overflow trap not taken");
  a_bound_in: assert property (acc && req_in.kind == esd_pkg::K_BOUND && !out_rng |=> !busy_out)
    else $error("range check raised inside limits");
  a_fpu_vec: assert property (acc && req_in.kind == esd_pkg::K_FPU && |fp_cond_in |=> st.vec == 8'h10)
    else $error("floating point error not on vector 16");
  a_simd_vec: assert property (acc && req_in.kind == esd_pkg::K_SIMD && |fp_cond_in |=> st.vec == esd_pkg::VEC_XF)
    else $error("packed error on wrong vector");
  a_soft_vec: assert property (acc && req_in.kind == esd_pkg::K_SOFT |=> st.vec == $past(req_in.vector))
    else $error("soft interrupt vector lost");
  a_no_implicit: assert property (acc && req_in.kind inside {esd_pkg::K_BRK, esd_pkg::K_FPU} |=> !st.status[esd_pkg::EV_OF] || $past(st.status[esd_pkg::EV_OF]))
    else $error("overflow raised implicitly");
  a_push_wide: assert property (mem_out.req && mem_out.we && st.fsm == esd_pkg::S_PUSH && st.mode == esd_pkg::ESD_LONG |-> mem_out.bytes == 4'h8)
    else $error("long mode push not 8 bytes");
  a_null_ss: assert property (st.fsm == esd_pkg::S_REDIR && !st.is_ret && st.mode == esd_pkg::ESD_LONG && st.chg |=> redir_out.valid && redir_out.ctx.ss == 16'h0000)
    else $error("stack selector not null");
  a_redir_end: assert property (st.fsm == esd_pkg::S_REDIR |=> redir_out.valid && done_out && !busy_out ##1 !redir_out.valid)
    else $error("redirect pulse malformed");

endmodule

// [sim/esd_mem_model.sv]
// stack and handler table memory seen by the dispatch unit
module esd_mem_model (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire esd_pkg::esd_mem_t mem_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic [63:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem [logic [63:0]];
  logic [63:0] last;
  logic waited;
  // slow mode inserts one wait state; idle data is the inverse of the last word
  assign ack_out = mem_in.req && (!slow_in || waited);
  // unwritten table entries hold a pattern tied to their address
  assign rdata_out = !ack_out ? ~last : mem.exists(mem_in.addr) ? mem[mem_in.addr] :
    {32'h0, 8'h5a, mem_in.addr[7:0], 8'ha5, mem_in.addr[7:0]};
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      waited <= 1'b0;
      last <= '0;
    end else begin
      waited <= mem_in.req && !ack_out;
      if (ack_out) begin
        last <= rdata_out;
        if (mem_in.we) mem[mem_in.addr] = mem_in.wdata;
      end
    end
  end
endmodule

// [sim/tb_top.sv]
// self-checking bench for the exception dispatch unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    esd_pkg::esd_kind_t k;
    logic [7:0] v;
    logic o;
    logic [31:0] op;
    logic [5:0] c;
    logic t;
    logic [7:0] e;
  } esd_row_t;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, rv = 0, slow = 0, lm = 0;
  logic ack, busy, done, irq;
  logic [7:0] ad = '0;
  logic [31:0] wd = '0, rdat, d;
  logic [5:0] fc = '0;
  logic [63:0] mrd;
  esd_pkg::esd_req_t rq = '0, r;
  esd_pkg::esd_redir_t rdr, got;
  esd_pkg::esd_mem_t mo;
  int num_errors = 0, tests_run = 0;
  esd_row_t rows [10] = '{
    '{esd_pkg::K_SOFT, 8'h21, 0, 0, 0, 1, 8'h21}, '{esd_pkg::K_SOFT, 8'h04, 0, 0, 0, 1, 8'h04},
    '{esd_pkg::K_BRK, 8'h00, 0, 0, 0, 1, 8'h03}, '{esd_pkg::K_OVF, 8'h00, 1, 0, 0, 1, 8'h04},
    '{esd_pkg::K_OVF, 8'h00, 0, 0, 0, 0, 8'h00}, '{esd_pkg::K_BOUND, 8'h00, 0, 9, 0, 1, 8'h05},
    '{esd_pkg::K_BOUND, 8'h00, 0, 8, 0, 0, 8'h00}, '{esd_pkg::K_FPU, 8'h00, 0, 0, 6'h01, 1, 8'h10},
    '{esd_pkg::K_FPU, 8'h00, 0, 0, 6'h00, 0, 8'h00}, '{esd_pkg::K_SIMD, 8'h00, 0, 0, 6'h20, 1, 8'h13}};
  esd_dispatch esd_dispatch_inst (.ref_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(ad), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .req_valid_in(rv), .req_in(rq), .fp_cond_in(fc),
    .busy_out(busy), .done_out(done), .redir_out(rdr), .mem_out(mo), .mem_ack_in(ack), .mem_rdata_in(mrd),
    .irq_out(irq));
  esd_mem_model esd_mem_model_inst (.ref_clk_in(clk), .rst_b_in(rst_b), .mem_in(mo), .slow_in(slow),
    .ack_out(ack), .rdata_out(mrd));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] s, input logic [63:0] e, input string n);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    ad <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdat;
  endtask
  task automatic run(input esd_pkg::esd_req_t q);
    @(posedge clk);
    rq <= q;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    // a trap that falls through pulses done right after the taking edge
    #1;
    for (int i = 0; i < 100 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    got = rdr;
    chk(done, 1'b1, "done");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // long mode: every stack store is eight bytes wide
  always @(negedge clk) if (lm && mo.req && mo.we && ack) chk(mo.bytes, 4'h8, "push bytes");
  initial forever #5 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wreg(esd_pkg::OFS_MASK, 32'hff);
    foreach (rows[i]) begin
      r = '0;
      r.kind = rows[i].k;
      r.vector = rows[i].v;
      r.ovf = rows[i].o;
      r.operand = rows[i].op;
      r.upper = 8;
      r.ctx.sp = 64'h800;
      fc <= rows[i].c;
      slow <= i[0];
      run(r);
      chk(got.valid, rows[i].t, "taken");
      if (rows[i].t) begin
        chk(got.ctx.ip[15:0], {8'ha5, rows[i].e[5:0], 2'b0}, "ip");
        chk(got.ctx.cs, {8'h5a, rows[i].e[5:0], 2'b0}, "cs");
        chk(got.ctx.sp, 64'h7fa, "sp");
        rreg(esd_pkg::OFS_LASTVEC, d);
        chk(d[7:0], rows[i].e, "vector");
      end
    end
    chk(irq, 1'b1, "irq");
    wreg(esd_pkg::OFS_MASK, 32'h0);
    @(posedge clk);
    #1;
    chk(irq, 1'b0, "irq masked");
    wreg(esd_pkg::OFS_STATUS, 32'hff);
    rreg(esd_pkg::OFS_STATUS, d);
    chk(d, 32'h0, "status");
    // real mode return pops what the dispatch pushed
    r = '0;
    r.kind = esd_pkg::K_SOFT;
    r.vector = 8'h30;
    r.ctx = '{32'h246, 64'h1234, 16'h700, 16'h0, 64'h400};
    run(r);
    r.kind = esd_pkg::K_RET;
    r.ctx.sp = 64'h3fa;
    run(r);
    chk({got.ctx.flags[15:0], got.ctx.ip[15:0], got.ctx.cs}, 48'h0246_1234_0700, "resume");
    chk(got.ctx.sp, 64'h400, "resume sp");
    wreg(esd_pkg::OFS_CTRL, 32'h2);
    lm = 1'b1;
    r = '0;
    r.kind = esd_pkg::K_SOFT;
    r.vector = 8'h20;
    r.current_privilege = 2'h3;
    r.ctx.ss = 16'h2b;
    r.ctx.sp = 64'h8000;
    run(r);
    chk(got.code64, 1'b1, "code64");
    chk(got.ctx.ss, esd_pkg::NULL_SEL, "null ss");
    chk(got.ctx.sp, 64'h7fd8, "long sp");
    r.system_mgmt_interrupt = 1'b1;
    run(r);
    chk(got.code64, 1'b0, "smi code");
    lm = 1'b0;
    // legacy task gate: state saved to the save area, then reloaded on return
    wreg(esd_pkg::OFS_CTRL, 32'h1);
    r = '0;
    r.kind = esd_pkg::K_SOFT;
    r.vector = 8'h22;
    r.task_gate = 1'b1;
    r.ctx = '{32'h202, 64'h5678, 16'h8, 16'h10, 64'h900};
    run(r);
    chk(got.ctx.ip, 64'h5a10_a510, "task ip");
    rreg(esd_pkg::OFS_STATUS, d);
    chk(d[esd_pkg::EV_TASK], 1'b1, "task event");
    r = '0;
    r.kind = esd_pkg::K_RET;
    run(r);
    chk(got.ctx.ip, 64'h5678, "task resume ip");
    chk({got.ctx.flags, got.ctx.cs, got.ctx.ss}, 64'h0000_0202_0008_0010, "task resume ctx");
    chk(got.ctx.sp, 64'h900, "task resume sp");
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rreg(esd_pkg::OFS_TSAVE, d);
    chk(d, esd_pkg::TSAVE_RST, "tsave");
    rreg(8'h1c, d);
    chk(d, 32'h0, "unmapped");
    complete_run();
  end
endmodule
